// ===== design/phy_clk_pkg.sv
// Package: constants and carriers for the PHY clocking block
// How it works
// - At gigabit the transmit side, inside and at the user stream, runs on one reference clock.
// - Every RGMII transmit data and control output leaves from a DDR output register pair.
// - The RGMII forwarded clock comes from a DDR output register pair like the data.
// - The RGMII forwarded clock is delayed 2 ns against data so its edges sit mid-window.
// - For RGMII receive the PHY clock samples the inputs and clocks all receive logic.
// - Transmit clocking may be shared by instances while each keeps its own receive clock.
// - RGMII moves data on both clock edges through DDR registers, halving the lines of GMII.
// - GMII/MII carries 10 Mb/s, 100 Mb/s and 1 Gb/s, with MII a subset of GMII.
// - In tri-speed GMII the transmit clock is selected by speed: reference at gigabit, PHY clock below.
// - A transmit clock enable is derived and the user side absorbs the nibble rate by handshake.
// - A receive clock enable is derived and receive delivery is throttled for the nibble width.
// - The GMII forwarded clock is the inverse of the reference, rising mid-window.
// - For GMII receive the PHY clock samples the inputs and clocks all receive logic.
// - The transmit enable is high every cycle at gigabit, one in ten at 100, one in a hundred at 10.
// - Over MII the 8-bit user streams transfer at most on every other cycle.
`default_nettype none

package phy_clk_pkg;

  // ==========================================================
  // Timing
  localparam int REF_MHZ      = 125;   // Gigabit reference rate
  localparam int TXC_DELAY_NS = 2;     // Forwarded clock lag
  localparam int TXC_DELAY_PS = TXC_DELAY_NS * 1000;
  localparam int DIV_100_DEF  = 10;    // Enable period at 100 Mb/s
  localparam int DIV_10_DEF   = 100;   // Enable period at 10 Mb/s
  localparam int DIV_MAX      = 128;   // Counter range

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    SPD_10   = 2'h0,
    SPD_100  = 2'h1,
    SPD_1000 = 2'h2
  } speed_t;

  typedef enum logic [1:0] {
    TX_BYTE = 2'h1,
    TX_HIGH = 2'h2
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_LOW  = 2'h1,
    RX_HIGH = 2'h2
  } rx_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] d;
    logic       en;
    logic       er;
  } gmii_t;

  typedef struct packed {
    logic [3:0] d_rise;
    logic [3:0] d_fall;
    logic       ctl_rise;
    logic       ctl_fall;
  } rgmii_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } ddr_clk_t;

  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } tx_byte_t;

  typedef struct packed {
    logic [7:0] data;
    logic       err;
    logic       first;
  } rx_byte_t;

  // ==========================================================
  // Reset values and fixed patterns
  localparam gmii_t    GMII_IDLE     = '0;
  localparam rgmii_t   RGMII_IDLE    = '0;
  localparam ddr_clk_t TXC_RGMII_PAT = '{rise: 1'h1, fall: 1'h0};
  localparam ddr_clk_t TXC_GMII_PAT  = '{rise: 1'h0, fall: 1'h1};

endpackage : phy_clk_pkg

`default_nettype wire

// ===== design/sync2.sv
// Two-flop synchroniser for levels entering a clock domain
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule : sync2

`default_nettype wire

// ===== design/phy_clocking.sv
// PHY-side clocking, enables and GMII/MII/RGMII data paths
`default_nettype none

module phy_clocking
  import phy_clk_pkg::*;
#(
  parameter int DIV_100 = DIV_100_DEF,
  parameter int DIV_10  = DIV_10_DEF
) (
  input  wire logic     mclk_in,
  input  wire logic     reset_n_in,
  input  wire logic [1:0] speed_in,
  input  wire logic     rgmii_mode_in,
  input  wire tx_byte_t tx_byte_in,
  input  wire logic     tx_valid_in,
  output logic          tx_ready_out,
  output logic          tx_ce_out,
  output logic          tx_clk_sel_out,
  output gmii_t         gmii_tx_out,
  output ddr_clk_t      gmii_txc_out,
  output rgmii_t        rgmii_tx_out,
  output ddr_clk_t      rgmii_txc_out,
  output logic [11:0]   txc_delay_ps_out,
  output logic          rx_busy_out,
  input  wire logic     rx_clk_in,
  input  wire gmii_t    gmii_rx_in,
  input  wire rgmii_t   rgmii_rx_in,
  output rx_byte_t      rx_byte_out,
  output logic          rx_valid_out,
  output logic          rx_ce_out
);

  // ==========================================================
  // Elaboration checks
  if (DIV_100 < 2 || DIV_100 > DIV_MAX || DIV_10 < 2 || DIV_10 > DIV_MAX)
  begin : g_bad_div
    $error("enable divider out of range");
  end

  // ==========================================================
  // Transmit domain: speed sync and enable generator
  logic [1:0] spd_raw;
  speed_t     spd;
  speed_t     spd_reg;
  logic [6:0] cnt_reg, cnt_next;
  logic [6:0] lim;
  logic       ce_reg, ce_next;
  logic       sel_reg;
  logic       rx_frame_reg;
  logic       rx_busy;

  // Speed straps come from pins, so two flops first
  sync2 #(.WIDTH(2)) u_spd_tx (
    .clk_in     (mclk_in),
    .reset_n_in (reset_n_in),
    .d_in       (speed_in),
    .q_out      (spd_raw)
  );
  assign spd = speed_t'(spd_raw);

  // Receive activity back into this domain as a level
  sync2 #(.WIDTH(1)) u_busy (
    .clk_in     (mclk_in),
    .reset_n_in (reset_n_in),
    .d_in       (rx_frame_reg),
    .q_out      (rx_busy)
  );

  // Enable divider; a speed change restarts a full period
  always_comb begin
    lim      = (spd == SPD_100) ? 7'(DIV_100 - 1) : 7'(DIV_10 - 1);
    cnt_next = cnt_reg + 7'h01;
    ce_next  = 1'b0;
    if (spd != spd_reg) begin
      cnt_next = '0;
    end else if (spd == SPD_1000) begin
      cnt_next = '0;
      ce_next  = 1'b1;
    end else if (cnt_reg == lim) begin
      cnt_next = '0;
      ce_next  = 1'b1;
    end
  end

  // ==========================================================
  // Transmit domain: byte and nibble sequencing
  tx_state_t tx_state_reg, tx_state_next;
  gmii_t     gtx_reg, gtx_next;
  rgmii_t    rtx_reg, rtx_next;
  logic [3:0] hi_reg, hi_next;
  logic       hier_reg, hier_next;
  logic       ready_reg, ready_next;
  logic       take;

  // Ready is predicted one cycle ahead so it leaves a flop
  always_comb begin
    tx_state_next = tx_state_reg;
    gtx_next      = gtx_reg;
    hi_next       = hi_reg;
    hier_next     = hier_reg;
    take          = tx_valid_in && ready_reg;
    if (ce_reg) begin
      unique case (tx_state_reg)
        TX_BYTE: begin
          gtx_next = GMII_IDLE;
          if (take) begin
            gtx_next.en = 1'b1;
            gtx_next.er = tx_byte_in.err;
            if (spd == SPD_1000) begin
              gtx_next.d = tx_byte_in.data;
            end else begin
              gtx_next.d    = {4'h0, tx_byte_in.data[3:0]};
              hi_next       = tx_byte_in.data[7:4];
              hier_next     = tx_byte_in.err;
              tx_state_next = TX_HIGH;
            end
          end
        end
        TX_HIGH: begin
          gtx_next.d    = {4'h0, hi_reg};
          gtx_next.en   = 1'b1;
          gtx_next.er   = hier_reg;
          tx_state_next = TX_BYTE;
        end
        default: begin
          tx_state_next = TX_BYTE;
        end
      endcase
    end
    // Both-edge mapping of the same byte onto the narrow link
    rtx_next.d_rise   = gtx_next.d[3:0];
    rtx_next.d_fall   = gtx_next.d[7:4];
    rtx_next.ctl_rise = gtx_next.en;
    rtx_next.ctl_fall = gtx_next.en ^ gtx_next.er;
    ready_next        = ce_next && (tx_state_next == TX_BYTE);
  end

  // All transmit state lives on the one reference clock
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spd_reg       <= SPD_10;
      cnt_reg       <= '0;
      ce_reg        <= 1'b0;
      sel_reg       <= 1'b0;
      tx_state_reg  <= TX_BYTE;
      gtx_reg       <= GMII_IDLE;
      rtx_reg       <= RGMII_IDLE;
      hi_reg        <= '0;
      hier_reg      <= 1'b0;
      ready_reg     <= 1'b0;
      rgmii_txc_out <= '0;
      gmii_txc_out  <= '0;
    end else begin
      spd_reg       <= spd;
      cnt_reg       <= cnt_next;
      ce_reg        <= ce_next;
      sel_reg       <= (spd == SPD_1000);
      tx_state_reg  <= tx_state_next;
      gtx_reg       <= gtx_next;
      rtx_reg       <= rtx_next;
      hi_reg        <= hi_next;
      hier_reg      <= hier_next;
      ready_reg     <= ready_next;
      rgmii_txc_out <= TXC_RGMII_PAT;
      gmii_txc_out  <= TXC_GMII_PAT;
    end
  end

  // Delay setting for the forwarded clock's output delay line
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txc_delay_ps_out <= '0;
    end else begin
      txc_delay_ps_out <= 12'(TXC_DELAY_PS);
    end
  end

  assign tx_ready_out   = ready_reg;
  assign tx_ce_out      = ce_reg;
  assign tx_clk_sel_out = sel_reg;
  assign gmii_tx_out    = gtx_reg;
  assign rgmii_tx_out   = rtx_reg;
  assign rx_busy_out    = rx_busy;

  // ==========================================================
  // Receive domain: reset release and configuration sync
  logic       rx_rst_n;
  logic [2:0] cfg_rx;
  logic       rgm;
  speed_t     rspd;
  logic       nib;

  // Reset asserts at once but releases on the PHY clock
  sync2 #(.WIDTH(1)) u_rst_rx (
    .clk_in     (rx_clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (1'b1),
    .q_out      (rx_rst_n)
  );

  // Each instance brings its own PHY clock, so it syncs its own copy
  sync2 #(.WIDTH(3)) u_cfg_rx (
    .clk_in     (rx_clk_in),
    .reset_n_in (reset_n_in),
    .d_in       ({rgmii_mode_in, speed_in}),
    .q_out      (cfg_rx)
  );
  assign rgm  = cfg_rx[2];
  assign rspd = speed_t'(cfg_rx[1:0]);
  assign nib  = !rgm && (rspd != SPD_1000);

  // ==========================================================
  // Receive domain: input registers and byte assembly
  gmii_t     gin_reg;
  rgmii_t    rin_reg;
  logic [7:0] byte_w;
  logic       dv_w, er_w;
  rx_state_t rx_state_reg, rx_state_next;
  logic [3:0] lo_reg, lo_next;
  logic       loer_reg, loer_next;
  logic       frame_next;
  rx_byte_t   rbyte_reg, rbyte_next;
  logic       rvalid_reg, rvalid_next;
  logic       rce_reg, rce_next;

  // Decode the sampled link, then pair nibbles below gigabit in GMII/MII mode only, not over RGMII
  always_comb begin
    if (rgm) begin
      byte_w = {rin_reg.d_fall, rin_reg.d_rise};
      dv_w   = rin_reg.ctl_rise;
      er_w   = rin_reg.ctl_rise ^ rin_reg.ctl_fall;
    end else begin
      byte_w = gin_reg.d;
      dv_w   = gin_reg.en;
      er_w   = gin_reg.er;
    end
    rx_state_next = rx_state_reg;
    lo_next       = lo_reg;
    loer_next     = loer_reg;
    frame_next    = rx_frame_reg;
    rbyte_next    = rbyte_reg;
    rvalid_next   = 1'b0;
    if (!dv_w) begin
      rx_state_next = RX_LOW;
      frame_next    = 1'b0;
    end else if (!nib) begin
      rvalid_next = 1'b1;
      rbyte_next  = '{data: byte_w, err: er_w, first: !rx_frame_reg};
      frame_next  = 1'b1;
    end else begin
      unique case (rx_state_reg)
        RX_LOW: begin
          lo_next       = byte_w[3:0];
          loer_next     = er_w;
          rx_state_next = RX_HIGH;
        end
        RX_HIGH: begin
          rvalid_next   = 1'b1;
          rbyte_next    = '{data: {byte_w[3:0], lo_reg},
                            err: er_w | loer_reg,
                            first: !rx_frame_reg};
          frame_next    = 1'b1;
          rx_state_next = RX_LOW;
        end
        default: begin
          rx_state_next = RX_LOW;
        end
      endcase
    end
    rce_next = !nib || rvalid_next;
  end

  // The PHY clock samples the pins and runs every receive flop
  always_ff @(posedge rx_clk_in or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      gin_reg      <= GMII_IDLE;
      rin_reg      <= RGMII_IDLE;
      rx_state_reg <= RX_LOW;
      lo_reg       <= '0;
      loer_reg     <= 1'b0;
      rx_frame_reg <= 1'b0;
      rbyte_reg    <= '0;
      rvalid_reg   <= 1'b0;
      rce_reg      <= 1'b0;
    end else begin
      gin_reg      <= gmii_rx_in;
      rin_reg      <= rgmii_rx_in;
      rx_state_reg <= rx_state_next;
      lo_reg       <= lo_next;
      loer_reg     <= loer_next;
      rx_frame_reg <= frame_next;
      rbyte_reg    <= rbyte_next;
      rvalid_reg   <= rvalid_next;
      rce_reg      <= rce_next;
    end
  end

  assign rx_byte_out  = rbyte_reg;
  assign rx_valid_out = rvalid_reg;
  assign rx_ce_out    = rce_reg;

  // ==========================================================
  // Checks
  logic [6:0] gap_reg;

  // Cycles since the last enable, saturating
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap_reg <= '0;
    end else if (ce_reg) begin
      gap_reg <= '0;
    end else if (gap_reg != 7'h7f) begin
      gap_reg <= gap_reg + 7'h01;
    end
  end

  ce_gig_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (spd == SPD_1000 && spd_reg == SPD_1000) |=> ce_reg)
    else $error("enable missing at gigabit");

  // The enable seen now was made under last cycle's speed, hence spd_reg
  ce_hundred_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (ce_reg && spd_reg == SPD_100) |-> gap_reg >= 7'(DIV_100 - 1))
    else $error("enable too frequent at 100");

  ce_ten_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (ce_reg && spd_reg == SPD_10) |-> gap_reg >= 7'(DIV_10 - 1))
    else $error("enable too frequent at 10");

  mii_ready_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (ready_reg && spd == SPD_100) |=> !ready_reg ##1 !ready_reg)
    else $error("nibble mode ready too soon");

  gig_take_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (take && spd == SPD_1000 && tx_state_reg == TX_BYTE && ce_reg)
    |=> gtx_reg.en && gtx_reg.d == $past(tx_byte_in.data))
    else $error("accepted byte not on the link");

  ddr_map_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    rtx_reg.d_rise == gtx_reg.d[3:0] && rtx_reg.d_fall == gtx_reg.d[7:4]
    && rtx_reg.ctl_fall == (gtx_reg.en ^ gtx_reg.er))
    else $error("double-rate mapping wrong");

  txc_phase_a: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    $past(reset_n_in) |-> gmii_txc_out.rise != rgmii_txc_out.rise
    && gmii_txc_out.fall == 1'b1)
    else $error("forwarded clock phase wrong");

  rx_gig_a: assert property (
    @(posedge rx_clk_in) disable iff (!rx_rst_n)
    (dv_w && !nib) |=> rvalid_reg && rbyte_reg.data == $past(byte_w))
    else $error("receive byte not delivered");

  rx_mii_a: assert property (
    @(posedge rx_clk_in) disable iff (!rx_rst_n)
    (rvalid_reg && nib) |=> !rvalid_reg)
    else $error("receive delivered on adjacent cycles");

endmodule : phy_clocking

`default_nettype wire

// ===== tb/phy_model.sv
// PHY model: drives the receive pins on the PHY clock
`default_nettype none

module phy_model
  import phy_clk_pkg::*;
(
  input  wire logic rx_clk_in,
  output var  gmii_t  gmii_rx_out,
  output var  rgmii_t rgmii_rx_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       busy;
  logic [9:0] junk;

  // ==========================================================
  // Idle lines
  // Lines toggle between frames so a stale byte never looks fresh
  initial begin
    busy = 1'b0;
    junk = 10'h02a5;
    gmii_rx_out = GMII_IDLE;
    rgmii_rx_out = RGMII_IDLE;
  end

  always @(posedge rx_clk_in) begin
    junk <= ~junk;
    if (!busy) begin
      gmii_rx_out  <= {junk[7:0], 2'h0};
      rgmii_rx_out <= {junk[7:0], 2'h0};
    end
  end

  // ==========================================================
  // Frame driver: mode 0 GMII bytes, 1 MII nibbles, 2 RGMII halves
  task automatic send(input int mode, input logic [8:0] q[$]);
    busy = 1'b1;
    foreach (q[i]) begin
      @(posedge rx_clk_in);
      if (mode == 1) begin
        gmii_rx_out <= {~q[i][3:0], q[i][3:0], 1'b1, q[i][8]};
        @(posedge rx_clk_in);
        gmii_rx_out <= {junk[3:0], q[i][7:4], 1'b1, q[i][8]};
      end else if (mode == 0) begin
        gmii_rx_out <= {q[i][7:0], 1'b1, q[i][8]};
      end else begin
        rgmii_rx_out <= {q[i][3:0], q[i][7:4], 1'b1, ~q[i][8]};
      end
    end
    // Release explicitly so the last unit is not held a cycle longer
    @(posedge rx_clk_in);
    gmii_rx_out  <= {junk[7:0], 2'h0};
    rgmii_rx_out <= {junk[7:0], 2'h0};
    busy = 1'b0;
  endtask : send

endmodule : phy_model

`default_nettype wire

// ===== tb/tb_gmii_rgmii_phy_clocking.sv
// Testbench for the PHY clocking and data path block
`default_nettype none

module tb_gmii_rgmii_phy_clocking
  import phy_clk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int D100 = 4;
  localparam int D10  = 8;

  logic       mclk_in, reset_n_in, rgmii_mode_in, tx_valid_in;
  logic       tx_ready_out, tx_ce_out, tx_clk_sel_out, rx_busy_out;
  logic       rx_clk_in, rx_valid_out, rx_ce_out;
  logic [1:0] speed_in;
  logic [11:0] txc_delay_ps_out;
  tx_byte_t   tx_byte_in;
  gmii_t      gmii_tx_out, gmii_rx_in;
  rgmii_t     rgmii_tx_out, rgmii_rx_in;
  ddr_clk_t   gmii_txc_out, rgmii_txc_out;
  rx_byte_t   rx_byte_out;
  int         failures, samples_checked, seed, cyc, last_take, gap_exp;
  logic       gig, up, prev_v, seen_busy;
  logic [9:0] tx_exp[$], tx_got[$], rx_exp[$], rx_got[$];

  phy_clocking #(.DIV_100(D100), .DIV_10(D10)) dut (
    .mclk_in, .reset_n_in, .speed_in, .rgmii_mode_in, .tx_byte_in,
    .tx_valid_in, .tx_ready_out, .tx_ce_out, .tx_clk_sel_out, .gmii_tx_out,
    .gmii_txc_out, .rgmii_tx_out, .rgmii_txc_out, .txc_delay_ps_out,
    .rx_busy_out, .rx_clk_in, .gmii_rx_in, .rgmii_rx_in, .rx_byte_out,
    .rx_valid_out, .rx_ce_out
  );

  phy_model model (
    .rx_clk_in, .gmii_rx_out(gmii_rx_in), .rgmii_rx_out(rgmii_rx_in)
  );

  // ==========================================================
  // Clocks: receive clock offset so the domains never line up
  always #5 mclk_in = ~mclk_in;

  initial begin
    rx_clk_in = 1'b0;
    #2.7;
    forever #6 rx_clk_in = ~rx_clk_in;
  end

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic drain(ref logic [9:0] g[$], ref logic [9:0] e[$]);
    check(16'(g.size()), 16'(e.size()));
    while (g.size() > 0 && e.size() > 0)
      check(16'(g.pop_front()), 16'(e.pop_front()));
    g.delete();
    e.delete();
  endtask : drain

  // ==========================================================
  // Transmit monitor: link units, take spacing, forwarded clocks
  always @(posedge mclk_in) begin
    cyc++;
    if (rx_busy_out === 1'b1)
      seen_busy = 1'b1;
    if (tx_valid_in && tx_ready_out) begin
      if (gap_exp != 0 && last_take >= 0)
        check(16'(cyc - last_take), 16'(gap_exp));
      last_take = cyc;
    end
    if (tx_ce_out && gmii_tx_out.en) begin
      tx_got.push_back({1'b0, gmii_tx_out.er, gmii_tx_out.d});
      // RGMII halves decoded back into a byte, valid on the rise
      if (gig)
        tx_got.push_back({~rgmii_tx_out.ctl_rise,
          rgmii_tx_out.ctl_rise ^ rgmii_tx_out.ctl_fall,
          rgmii_tx_out.d_fall, rgmii_tx_out.d_rise});
    end
    if (up) begin
      check({gmii_txc_out, rgmii_txc_out}, 16'h0006);
      check(txc_delay_ps_out, 16'h07d0);
    end
  end

  // Receive monitor: deliveries never adjacent over MII
  always @(posedge rx_clk_in) begin
    if (rx_valid_out) begin
      rx_got.push_back(rx_byte_out);
      if (!gig)
        check({prev_v, rx_ce_out}, 16'h0001);
    end
    if (gig && up)
      check(rx_ce_out, 16'h0001);
    prev_v <= rx_valid_out;
  end

  // ==========================================================
  // Stream tasks
  task automatic tx_put(input tx_byte_t b);
    int n;
    n = 0;
    tx_byte_in  <= b;
    tx_valid_in <= 1'b1;
    // Hold the byte until ready is seen at an edge
    do begin
      @(posedge mclk_in);
      n++;
    end while (tx_ready_out !== 1'b1 && n < 1000);
    if (n >= 1000)
      failures++;
    if (gig) begin
      tx_exp.push_back({1'b0, b.err, b.data});
      tx_exp.push_back({1'b0, b.err, b.data});
    end else begin
      tx_exp.push_back({1'b0, b.err, 4'h0, b.data[3:0]});
      tx_exp.push_back({1'b0, b.err, 4'h0, b.data[7:4]});
    end
  endtask : tx_put

  task automatic ce_period(input int per);
    int n;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      do begin
        @(posedge mclk_in);
        n++;
      end while (tx_ce_out !== 1'b1 && n < 300);
      if (k > 0)
        check(16'(n), 16'(per));
    end
  endtask : ce_period

  task automatic rx_frame(input int mode, input int len);
    logic [8:0] q[$];
    logic [8:0] b;
    rgmii_mode_in <= (mode == 2);
    repeat (6) @(posedge mclk_in);
    // First byte all ones, last byte flagged in error
    for (int i = 0; i < len; i++) begin
      b = (i == 0) ? 9'h00ff : {i == len - 1, 8'($random(seed))};
      q.push_back(b);
      rx_exp.push_back({b[7:0], b[8], i == 0});
    end
    seen_busy = 1'b0;
    model.send(mode, q);
    repeat (25) @(posedge mclk_in);
    check(seen_busy, 16'h0001);
    check(rx_busy_out, 16'h0000);
    drain(rx_got, rx_exp);
  endtask : rx_frame

  // ==========================================================
  // Main sequence: 1G, 100M, 10M
  initial begin
    logic [1:0] spd[3];
    int         per[3];
    spd = '{2'h2, 2'h1, 2'h0};
    per = '{1, D100, D10};
    seed = 28824;
    mclk_in = 1'b0;
    reset_n_in = 1'b0;
    speed_in = 2'h2;
    rgmii_mode_in = 1'b0;
    tx_valid_in = 1'b0;
    tx_byte_in = '0;
    {gig, up, prev_v, seen_busy} = '0;
    {cyc, gap_exp} = '0;
    last_take = -1;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    up = 1'b1;
    for (int i = 0; i < 3; i++) begin
      gig = 1'b0;
      gap_exp = 0;
      speed_in <= spd[i];
      repeat (40) @(posedge mclk_in);
      gig = (i == 0);
      check(tx_clk_sel_out, gig);
      ce_period(per[i]);
      gap_exp = gig ? 1 : 2 * per[i];
      last_take = -1;
      tx_put('{data: 8'h00, err: 1'b0});
      for (int k = 0; k < 6; k++)
        tx_put(tx_byte_t'($random(seed)));
      tx_put('{data: 8'hff, err: 1'b1});
      tx_valid_in <= 1'b0;
      repeat (3 * per[i] + 8) @(posedge mclk_in);
      drain(tx_got, tx_exp);
      if (gig) begin
        rx_frame(0, 8);
        rx_frame(2, 8);
      end else begin
        rx_frame(1, 6);
      end
    end
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400us;
    failures++;
    summarize();
  end

endmodule : tb_gmii_rgmii_phy_clocking

`default_nettype wire
